/* File: tcg_pkg.sv */
package tcg_pkg;
  // generator running modes
  typedef enum logic [2:0] {
    TCG_MODE_OFF       = 3'h0,
    TCG_MODE_FREE      = 3'h1,
    TCG_MODE_FREE_MUTE = 3'h2,
    TCG_MODE_REC_RUN   = 3'h3,
    TCG_MODE_AUTO_MUTE = 3'h4,
    TCG_MODE_EXT_LTC   = 3'h5,
    TCG_MODE_EXT_HALT  = 3'h6,
    TCG_MODE_EXT_VID   = 3'h7
  } tcg_mode_e;

  // file-stamp frame rates, audio mode
  typedef enum logic [2:0] {
    TCG_RATE_23976 = 3'h0,
    TCG_RATE_24    = 3'h1,
    TCG_RATE_25    = 3'h2,
    TCG_RATE_2997  = 3'h3,
    TCG_RATE_2997D = 3'h4,
    TCG_RATE_30    = 3'h5,
    TCG_RATE_30D   = 3'h6
  } tcg_rate_e;

  // take trigger state machine, gray along idle-qualify-armed
  typedef enum logic [1:0] {
    TCG_TRG_IDLE  = 2'b00,
    TCG_TRG_QUAL  = 2'b01,
    TCG_TRG_ARMED = 2'b11
  } tcg_trg_e;

  localparam logic [2:0] TCG_REF_A_INT = 3'h0;
  localparam logic [2:0] TCG_REF_A_WCLK = 3'h1;
  localparam logic [2:0] TCG_REF_A_VREF = 3'h2;
  localparam logic [2:0] TCG_REF_A_AES = 3'h3;
  localparam logic [2:0] TCG_REF_A_NET = 3'h4;
  localparam logic [2:0] TCG_REF_A_VIN = 3'h5;
  localparam logic [1:0] TCG_REF_V_INT = 2'h0;
  localparam logic [1:0] TCG_REF_V_VREF = 2'h1;
  localparam logic [1:0] TCG_REF_V_VIN = 2'h2;

  // sync out: 0 off, 1..19 genlock formats on internal clock, 20/21 follow video
  localparam logic [4:0] TCG_SYNC_OFF = 5'h00;
  localparam logic [4:0] TCG_SYNC_FMT_LAST = 5'h13;
  localparam logic [4:0] TCG_SYNC_GL_FOLLOW = 5'h14;
  localparam logic [4:0] TCG_SYNC_WC_FOLLOW = 5'h15;
  localparam logic [1:0] TCG_SYNC_SRC_NONE = 2'h0;
  localparam logic [1:0] TCG_SYNC_SRC_GEN = 2'h1;
  localparam logic [1:0] TCG_SYNC_SRC_GL_VIN = 2'h2;
  localparam logic [1:0] TCG_SYNC_SRC_WC_VIN = 2'h3;

  localparam logic [1:0] TCG_UB_USER = 2'h0;
  localparam logic [1:0] TCG_UB_MDY = 2'h1;
  localparam logic [1:0] TCG_UB_DMY = 2'h2;

  localparam logic [4:0] TCG_HOURS_MAX = 5'd23;
  localparam logic [5:0] TCG_MIN_MAX = 6'd59;
  localparam logic [5:0] TCG_SEC_MAX = 6'd59;
  localparam logic [4:0] TCG_FRAMES_RST = 5'h00;
  localparam logic [7:0] TCG_UB_RST = 8'h00;
  localparam logic [3:0] TCG_HOLDOFF_MAX = 4'd8;
  localparam logic signed [4:0] TCG_OFS_MIN = -5'sd10;
  localparam logic signed [4:0] TCG_OFS_MAX = 5'sd10;

  // one second tick at 10 MHz system clock
  localparam int TCG_CLK_HZ = 10000000;
  localparam int TCG_SEC_MS = 1000;
  localparam logic [23:0] TCG_SEC_CYC = 24'(TCG_CLK_HZ / 1000 * TCG_SEC_MS);
endpackage

/* File: tcg_frame_cnt.sv */
`timescale 1ns/100ps
// frame counter with rollover and drop-frame skipping
module tcg_frame_cnt (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [4:0] ld_hh,
  input wire logic [5:0] ld_mm,
  input wire logic [5:0] ld_ss,
  input wire logic [4:0] ld_ff,
  input wire logic adv,
  input wire logic drop_frame_variant,
  input wire logic [4:0] last_frame,
  output logic [4:0] hh_q,
  output logic [5:0] mm_q,
  output logic [5:0] ss_q,
  output logic [4:0] ff_q
);
  logic [4:0] hh_d;
  logic [5:0] mm_d;
  logic [5:0] ss_d;
  logic [4:0] ff_d;
  wire f_wrap = (ff_q >= last_frame);
  wire s_wrap = f_wrap && (ss_q == tcg_pkg::TCG_SEC_MAX);
  wire m_wrap = s_wrap && (mm_q == tcg_pkg::TCG_MIN_MAX);
  wire h_wrap = m_wrap && (hh_q == tcg_pkg::TCG_HOURS_MAX);
  wire [5:0] mm_nx = m_wrap ? 6'h00 : mm_q + 6'h01;
  // skip frames 0 and 1 on new minute unless minute is a multiple of ten
  wire skip = drop_frame_variant && s_wrap && ((mm_nx % 6'd10) != 6'h00);

  always_comb begin
    hh_d = hh_q;
    mm_d = mm_q;
    ss_d = ss_q;
    ff_d = ff_q;
    if (load) begin
      hh_d = ld_hh;
      mm_d = ld_mm;
      ss_d = ld_ss;
      ff_d = ld_ff;
    end else if (adv) begin
      ff_d = f_wrap ? (skip ? 5'h02 : 5'h00) : ff_q + 5'h01;
      if (f_wrap) ss_d = s_wrap ? 6'h00 : ss_q + 6'h01;
      if (s_wrap) mm_d = mm_nx;
      if (m_wrap) hh_d = h_wrap ? 5'h00 : hh_q + 5'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hh_q <= 5'h00;
      mm_q <= 6'h00;
      ss_q <= 6'h00;
      ff_q <= tcg_pkg::TCG_FRAMES_RST;
    end else if (clk_en) begin
      hh_q <= hh_d;
      mm_q <= mm_d;
      ss_q <= ss_d;
      ff_q <= ff_d;
    end
  end
endmodule // tcg_frame_cnt

/* File: tcg_top.sv */
`timescale 1ns/100ps
module tcg_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic frame_tick,
  input wire logic [2:0] tc_mode,
  input wire logic video_mode,
  input wire logic recording,
  input wire logic drop_frame_en,
  input wire logic [2:0] file_rate,
  input wire logic preset_stb,
  input wire logic [4:0] preset_hh,
  input wire logic [5:0] preset_mm,
  input wire logic [5:0] preset_ss,
  input wire logic [4:0] preset_ff,
  input wire logic [1:0] ub_slot_sel,
  input wire logic ub_wr,
  input wire logic [7:0] ub_wdata,
  input wire logic [1:0] ub_format,
  input wire logic [7:0] sys_month,
  input wire logic [7:0] sys_day,
  input wire logic [7:0] sys_year,
  input wire logic [4:0] tod_hh,
  input wire logic [5:0] tod_mm,
  input wire logic [5:0] tod_ss,
  input wire logic jam_rx_stb,
  input wire logic jam_tod_stb,
  input wire logic rx_valid,
  input wire logic [4:0] rx_hh,
  input wire logic [5:0] rx_mm,
  input wire logic [5:0] rx_ss,
  input wire logic [4:0] rx_ff,
  input wire logic [31:0] rx_user_bits,
  input wire logic tc_trigger_en,
  input wire logic [3:0] holdoff_sec,
  input wire logic signed [4:0] start_offset,
  input wire logic file_start_stb,
  input wire logic [2:0] audio_ref_sel,
  input wire logic [1:0] video_ref_sel,
  input wire logic [4:0] sync_out_sel,
  input wire logic jam_view_open,
  output logic [23:0] generator_timecode_value,
  output logic [31:0] user_bit_groups,
  output logic gen_drop_frame_q,
  output logic gen_running_q,
  output logic gen_mute_q,
  output logic [23:0] file_start_tc_q,
  output logic [2:0] file_rate_q,
  output logic take_start_q,
  output logic [2:0] clk_ref_q,
  output logic [1:0] sync_src_q,
  output logic [4:0] sync_fmt_q,
  output logic [23:0] view_rx_tc_q,
  output logic [31:0] view_rx_ub_q,
  output logic [23:0] view_gen_tc_q,
  output logic [31:0] view_gen_ub_q
);
  logic [7:0] user_bit_slots [4];
  logic [4:0] hh;
  logic [5:0] mm;
  logic [5:0] ss;
  logic [4:0] ff;
  tcg_pkg::tcg_trg_e trg_q;
  tcg_pkg::tcg_trg_e trg_d;
  logic [23:0] sec_cnt_q;
  logic [3:0] held_q;

  function automatic logic [4:0] last_of(input logic [2:0] r);
    case (r)
      tcg_pkg::TCG_RATE_25: last_of = 5'd24;
      tcg_pkg::TCG_RATE_23976, tcg_pkg::TCG_RATE_24: last_of = 5'd23;
      default: last_of = 5'd29;
    endcase
  endfunction

  function automatic logic is_drop(input logic [2:0] r);
    is_drop = (r == tcg_pkg::TCG_RATE_2997D) || (r == tcg_pkg::TCG_RATE_30D);
  endfunction

  // video mode ignores the audio file rate; uses 29.97 counting plus drop enable
  wire [2:0] eff_rate = video_mode ? tcg_pkg::TCG_RATE_2997 : file_rate;
  wire drop_frame_variant = drop_frame_en || (!video_mode && is_drop(file_rate));
  wire [2:0] mode = tc_mode;
  wire ext_mode = (mode == tcg_pkg::TCG_MODE_EXT_LTC) || (mode == tcg_pkg::TCG_MODE_EXT_HALT)
    || (mode == tcg_pkg::TCG_MODE_EXT_VID);
  wire run_free = (mode == tcg_pkg::TCG_MODE_FREE) || (mode == tcg_pkg::TCG_MODE_FREE_MUTE);
  wire run_rec = (mode == tcg_pkg::TCG_MODE_REC_RUN) && recording;
  // ltc halt freezes the generator when the received code drops out
  wire run_ext = ext_mode && (rx_valid || mode != tcg_pkg::TCG_MODE_EXT_HALT);
  wire running = run_free || run_rec || run_ext;
  wire mute = (mode == tcg_pkg::TCG_MODE_FREE_MUTE) || (mode == tcg_pkg::TCG_MODE_AUTO_MUTE)
    ? !recording : (mode == tcg_pkg::TCG_MODE_OFF);
  // ext modes follow the received value on each valid frame
  wire ext_follow = ext_mode && rx_valid && frame_tick;
  wire do_jam_rx = jam_rx_stb || ext_follow;
  wire load = preset_stb || jam_tod_stb || do_jam_rx;
  // priority: preset, then time of day, then received code
  wire [4:0] ld_hh = preset_stb ? preset_hh : jam_tod_stb ? tod_hh : rx_hh;
  wire [5:0] ld_mm = preset_stb ? preset_mm : jam_tod_stb ? tod_mm : rx_mm;
  wire [5:0] ld_ss = preset_stb ? preset_ss : jam_tod_stb ? tod_ss : rx_ss;
  wire [4:0] ld_ff = preset_stb ? preset_ff : jam_tod_stb ? 5'h00 : rx_ff;

  tcg_frame_cnt u_cnt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .load(load),
    .ld_hh(ld_hh),
    .ld_mm(ld_mm),
    .ld_ss(ld_ss),
    .ld_ff(ld_ff),
    .adv(frame_tick && running),
    .drop_frame_variant(drop_frame_variant),
    .last_frame(last_of(eff_rate)),
    .hh_q(hh),
    .mm_q(mm),
    .ss_q(ss),
    .ff_q(ff)
  );

  // packed binary fields, frames in the low five bits for the stamp splice
  wire [23:0] gen_tc = {2'b00, hh, mm, ss, ff};

  // user bit slots; date layouts overwrite slots 0..2
  wire date_fmt = (ub_format == tcg_pkg::TCG_UB_MDY) || (ub_format == tcg_pkg::TCG_UB_DMY);
  wire [7:0] ub0 = (ub_format == tcg_pkg::TCG_UB_MDY) ? sys_month
    : (ub_format == tcg_pkg::TCG_UB_DMY) ? sys_day : user_bit_slots[0];
  wire [7:0] ub1 = (ub_format == tcg_pkg::TCG_UB_MDY) ? sys_day
    : (ub_format == tcg_pkg::TCG_UB_DMY) ? sys_month : user_bit_slots[1];
  wire [7:0] ub2 = date_fmt ? sys_year : user_bit_slots[2];
  wire [31:0] gen_ub = {ub0, ub1, ub2, user_bit_slots[3]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ub
      // grayed slots refuse writes in date layouts
      wire wr_ok = ub_wr && (ub_slot_sel == 2'(gi)) && (gi == 3 || !date_fmt);
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          user_bit_slots[gi] <= tcg_pkg::TCG_UB_RST;
        end else if (clk_en && wr_ok) begin
          user_bit_slots[gi] <= ub_wdata;
        end
      end
    end
  endgenerate

  // file start stamp: offset in frames, generator output untouched
  wire signed [4:0] ofs = (start_offset > tcg_pkg::TCG_OFS_MAX) ? tcg_pkg::TCG_OFS_MAX
    : (start_offset < tcg_pkg::TCG_OFS_MIN) ? tcg_pkg::TCG_OFS_MIN : start_offset;
  wire signed [6:0] ff_ofs = $signed({2'b00, ff}) + 7'(ofs);
  // limitation: offset saturates inside the current second, no borrow/carry
  wire [4:0] ff_stamp = (ff_ofs < 7'sd0) ? 5'h00
    : (ff_ofs > $signed({2'b00, last_of(eff_rate)})) ? last_of(eff_rate) : ff_ofs[4:0];

  // hold-off qualifier for timecode-triggered takes
  wire [3:0] hold_lim = (holdoff_sec > tcg_pkg::TCG_HOLDOFF_MAX) ? tcg_pkg::TCG_HOLDOFF_MAX : holdoff_sec;
  wire sec_tick = (sec_cnt_q == tcg_pkg::TCG_SEC_CYC - 24'h1);
  wire qual_done = (held_q >= hold_lim);
  always_comb begin
    trg_d = trg_q;
    case (trg_q)
      tcg_pkg::TCG_TRG_IDLE: if (tc_trigger_en && rx_valid) trg_d = tcg_pkg::TCG_TRG_QUAL;
      tcg_pkg::TCG_TRG_QUAL: begin
        if (!rx_valid || !tc_trigger_en) trg_d = tcg_pkg::TCG_TRG_IDLE;
        else if (qual_done) trg_d = tcg_pkg::TCG_TRG_ARMED;
      end
      tcg_pkg::TCG_TRG_ARMED: if (!rx_valid || !tc_trigger_en) trg_d = tcg_pkg::TCG_TRG_IDLE;
      default: trg_d = tcg_pkg::TCG_TRG_IDLE;
    endcase
  end
  wire fire = (trg_q == tcg_pkg::TCG_TRG_QUAL) && trg_d == tcg_pkg::TCG_TRG_ARMED;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trg_q <= tcg_pkg::TCG_TRG_IDLE;
      sec_cnt_q <= 24'h000000;
      held_q <= 4'h0;
    end else if (clk_en) begin
      trg_q <= trg_d;
      sec_cnt_q <= (trg_q != tcg_pkg::TCG_TRG_QUAL || sec_tick) ? 24'h000000 : sec_cnt_q + 24'h000001;
      held_q <= (trg_q != tcg_pkg::TCG_TRG_QUAL) ? 4'h0 : held_q + {3'b000, sec_tick};
    end
  end

  // reference and sync-out selection
  wire [2:0] ref_sel = video_mode ? {1'b0, video_ref_sel} : audio_ref_sel;
  wire [1:0] sync_src = (sync_out_sel == tcg_pkg::TCG_SYNC_OFF) ? tcg_pkg::TCG_SYNC_SRC_NONE
    : (sync_out_sel <= tcg_pkg::TCG_SYNC_FMT_LAST) ? tcg_pkg::TCG_SYNC_SRC_GEN
    : (sync_out_sel == tcg_pkg::TCG_SYNC_GL_FOLLOW) ? tcg_pkg::TCG_SYNC_SRC_GL_VIN
    : (sync_out_sel == tcg_pkg::TCG_SYNC_WC_FOLLOW) ? tcg_pkg::TCG_SYNC_SRC_WC_VIN
    : tcg_pkg::TCG_SYNC_SRC_NONE;
  wire ref_ok = video_mode ? (video_ref_sel <= tcg_pkg::TCG_REF_V_VIN) : (audio_ref_sel <= tcg_pkg::TCG_REF_A_VIN);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      generator_timecode_value <= 24'h000000;
      user_bit_groups <= 32'h00000000;
      gen_drop_frame_q <= 1'b0;
      gen_running_q <= 1'b0;
      gen_mute_q <= 1'b1;
      file_start_tc_q <= 24'h000000;
      file_rate_q <= tcg_pkg::TCG_RATE_2997;
      take_start_q <= 1'b0;
      clk_ref_q <= tcg_pkg::TCG_REF_A_INT;
      sync_src_q <= tcg_pkg::TCG_SYNC_SRC_NONE;
      sync_fmt_q <= tcg_pkg::TCG_SYNC_OFF;
      view_rx_tc_q <= 24'h000000;
      view_rx_ub_q <= 32'h00000000;
      view_gen_tc_q <= 24'h000000;
      view_gen_ub_q <= 32'h00000000;
    end else if (clk_en) begin
      generator_timecode_value <= gen_tc;
      user_bit_groups <= gen_ub;
      gen_drop_frame_q <= drop_frame_variant;
      gen_running_q <= running;
      gen_mute_q <= mute;
      if (file_start_stb) begin
        file_start_tc_q <= {gen_tc[23:5], ff_stamp};
        file_rate_q <= eff_rate;
      end
      take_start_q <= fire;
      if (ref_ok) clk_ref_q <= ref_sel;
      sync_src_q <= sync_src;
      sync_fmt_q <= (sync_src == tcg_pkg::TCG_SYNC_SRC_GEN) ? sync_out_sel : tcg_pkg::TCG_SYNC_OFF;
      if (jam_view_open) begin
        view_rx_tc_q <= {2'b00, rx_hh, rx_mm, rx_ss, rx_ff};
        view_rx_ub_q <= rx_user_bits;
        view_gen_tc_q <= gen_tc;
        view_gen_ub_q <= gen_ub;
      end
    end
  end
endmodule // tcg_top

/* File: tcg_top_asserts.sv */
`timescale 1ns/100ps
module tcg_top_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic preset_stb,
  input wire logic [4:0] preset_hh,
  input wire logic [5:0] preset_mm,
  input wire logic [5:0] preset_ss,
  input wire logic [4:0] preset_ff,
  input wire logic [23:0] generator_timecode_value,
  input wire logic ub_wr,
  input wire logic [1:0] ub_slot_sel,
  input wire logic [7:0] ub_wdata,
  input wire logic [1:0] ub_format,
  input wire logic [31:0] user_bit_groups,
  input wire logic take_start_q,
  input wire logic tc_trigger_en,
  input wire logic rx_valid,
  input wire logic [2:0] tc_mode,
  input wire logic gen_mute_q,
  input wire logic [4:0] sync_out_sel,
  input wire logic [1:0] sync_src_q,
  input wire logic video_mode,
  input wire logic [1:0] video_ref_sel,
  input wire logic [2:0] clk_ref_q,
  input wire logic jam_view_open,
  input wire logic [23:0] view_gen_tc_q,
  input wire logic file_start_stb,
  input wire logic [2:0] file_rate,
  input wire logic [2:0] file_rate_q
);
  default clocking @(posedge sys_clk); endclocking
  // frozen cycles carry no obligation
  default disable iff (!rst_n || !clk_en);
  logic [23:0] pre_w;
  logic [7:0] slot_w;
  logic [1:0] sel_q;
  logic [7:0] dat_q;
  assign pre_w = {2'h0, preset_hh, preset_mm, preset_ss, preset_ff};
  assign slot_w = 8'(user_bit_groups >> {~sel_q, 3'h0});
  always_ff @(posedge sys_clk) begin
    if (ub_wr) begin
      sel_q <= ub_slot_sel;
      dat_q <= ub_wdata;
    end
  end
  preset_load_a: assert property (preset_stb |-> ##2 generator_timecode_value == $past(pre_w, 2))
    else $error("preset value not shown two cycles later");
  ub_write_a: assert property ((ub_wr && ub_format == tcg_pkg::TCG_UB_USER) ##1 (!ub_wr) [*2] |=> slot_w == dat_q)
    else $error("user bit slot not written");
  take_pulse_a: assert property (take_start_q |-> $past(tc_trigger_en) && $past(rx_valid) ##1 !take_start_q)
    else $error("take pulse without valid code or too long");
  mute_off_a: assert property (tc_mode == tcg_pkg::TCG_MODE_OFF [*2] |-> gen_mute_q)
    else $error("off mode not muted");
  sync_follow_a: assert property (sync_out_sel == tcg_pkg::TCG_SYNC_GL_FOLLOW |=> sync_src_q == tcg_pkg::TCG_SYNC_SRC_GL_VIN)
    else $error("sync out not following video");
  vid_ref_a: assert property (video_mode && video_ref_sel == tcg_pkg::TCG_REF_V_VIN |=> clk_ref_q == 3'h2)
    else $error("video reference not selected");
  view_hold_a: assert property (!jam_view_open |=> $stable(view_gen_tc_q))
    else $error("view changed while closed");
  stamp_rate_a: assert property (file_start_stb && !video_mode |=> file_rate_q == $past(file_rate))
    else $error("stamp rate not taken");
  cover property (take_start_q);
  cover property (preset_stb);
  cover property (jam_view_open && rx_valid);
endmodule // tcg_top_asserts
bind tcg_top tcg_top_asserts tcg_top_asserts_i (.sys_clk, .rst_n, .clk_en, .preset_stb, .preset_hh, .preset_mm,
  .preset_ss, .preset_ff, .generator_timecode_value, .ub_wr, .ub_slot_sel, .ub_wdata, .ub_format, .user_bit_groups,
  .take_start_q, .tc_trigger_en, .rx_valid, .tc_mode, .gen_mute_q, .sync_out_sel, .sync_src_q, .video_mode,
  .video_ref_sel, .clk_ref_q, .jam_view_open, .view_gen_tc_q, .file_start_stb, .file_rate, .file_rate_q);

/* File: tcg_rx_src.sv */
`timescale 1ns/100ps
// far timecode source; counts frames only, runs stay short
module tcg_rx_src (
  input wire logic sys_clk,
  input wire logic src_on,
  input wire logic tick,
  output logic rx_valid,
  output logic [4:0] rx_hh,
  output logic [5:0] rx_mm,
  output logic [5:0] rx_ss,
  output logic [4:0] rx_ff,
  output logic [31:0] rx_user_bits
);
  logic [21:0] tc_q = {5'h01, 6'h02, 6'h03, 5'h04};
  logic flip_q = 1'b0;
  always @(posedge sys_clk) begin
    flip_q <= ~flip_q;
    if (src_on && tick) tc_q <= tc_q + 22'h1;
  end
  assign rx_valid = src_on;
  // released line alternates each cycle between the old code and its inverse
  assign {rx_hh, rx_mm, rx_ss, rx_ff} = src_on ? tc_q : ~tc_q ^ {22{flip_q}};
  assign rx_user_bits = src_on ? 32'h5a3c0f81 : {32{flip_q}};
endmodule // tcg_rx_src

/* File: tcg_top_tb_top.sv */
`timescale 1ns/100ps
module tcg_top_tb_top;
  logic sys_clk, rst_n, clk_en, frame_tick, video_mode, recording, drop_frame_en, preset_stb, ub_wr, src_on;
  logic jam_rx_stb, jam_tod_stb, tc_trigger_en, file_start_stb, jam_view_open, rx_valid;
  logic gen_drop_frame_q, gen_running_q, gen_mute_q, take_start_q;
  logic [1:0] ub_slot_sel, ub_format, video_ref_sel, sync_src_q;
  logic [2:0] tc_mode, file_rate, audio_ref_sel, file_rate_q, clk_ref_q;
  logic [3:0] holdoff_sec;
  logic [4:0] preset_hh, preset_ff, tod_hh, sync_out_sel, rx_hh, rx_ff, sync_fmt_q;
  logic signed [4:0] start_offset;
  logic [5:0] preset_mm, preset_ss, tod_mm, tod_ss, rx_mm, rx_ss;
  logic [7:0] ub_wdata, sys_month, sys_day, sys_year;
  logic [23:0] generator_timecode_value, file_start_tc_q, view_rx_tc_q, view_gen_tc_q;
  logic [31:0] rx_user_bits, user_bit_groups, view_rx_ub_q, view_gen_ub_q;
  int errors, checks_done;
  tcg_top tcg_top_i (.sys_clk, .rst_n, .clk_en, .frame_tick, .tc_mode, .video_mode, .recording, .drop_frame_en,
    .file_rate, .preset_stb, .preset_hh, .preset_mm, .preset_ss, .preset_ff, .ub_slot_sel, .ub_wr, .ub_wdata,
    .ub_format, .sys_month, .sys_day, .sys_year, .tod_hh, .tod_mm, .tod_ss, .jam_rx_stb, .jam_tod_stb, .rx_valid,
    .rx_hh, .rx_mm, .rx_ss, .rx_ff, .rx_user_bits, .tc_trigger_en, .holdoff_sec, .start_offset, .file_start_stb,
    .audio_ref_sel, .video_ref_sel, .sync_out_sel, .jam_view_open, .generator_timecode_value, .user_bit_groups,
    .gen_drop_frame_q, .gen_running_q, .gen_mute_q, .file_start_tc_q, .file_rate_q, .take_start_q, .clk_ref_q,
    .sync_src_q, .sync_fmt_q, .view_rx_tc_q, .view_rx_ub_q, .view_gen_tc_q, .view_gen_ub_q);
  tcg_rx_src tcg_rx_src_i (.sys_clk, .src_on, .tick(frame_tick), .rx_valid, .rx_hh, .rx_mm, .rx_ss, .rx_ff,
    .rx_user_bits);
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [31:0] tc(input logic [4:0] h, input logic [5:0] m, input logic [5:0] s, input logic [4:0] f);
    return {10'h0, h, m, s, f};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic preset(input logic [4:0] h, input logic [5:0] m, input logic [5:0] s, input logic [4:0] f);
    {preset_hh, preset_mm, preset_ss, preset_ff} = {h, m, s, f};
    preset_stb = 1'b1;
    cyc(1);
    preset_stb = 1'b0;
    cyc(2);
  endtask
  task automatic tick();
    frame_tick = 1'b1;
    cyc(1);
    frame_tick = 1'b0;
    cyc(2);
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    ub_slot_sel = s;
    ub_wdata = d;
    ub_wr = 1'b1;
    cyc(1);
    ub_wr = 1'b0;
    cyc(3);
  endtask
  task automatic stamp();
    file_start_stb = 1'b1;
    cyc(1);
    file_start_stb = 1'b0;
    cyc(1);
  endtask
  task automatic t_rst();
    chk("gen", generator_timecode_value, 0);
    chk("ub", user_bit_groups, 0);
    chk("df", gen_drop_frame_q, 0);
    chk("rate", file_rate_q, 3);
    chk("ref", clk_ref_q, 0);
    chk("take", take_start_q, 0);
  endtask
  task automatic t_count();
    tc_mode = tcg_pkg::TCG_MODE_FREE;
    preset(23, 59, 59, 29);
    chk("gen", generator_timecode_value, tc(23, 59, 59, 29));
    tick();
    chk("gen", generator_timecode_value, 0);
    drop_frame_en = 1'b1;
    preset(0, 0, 59, 29);
    tick();
    chk("gen", generator_timecode_value, tc(0, 1, 0, 2));
    chk("df", gen_drop_frame_q, 1);
    preset(0, 9, 59, 29);
    tick();
    chk("gen", generator_timecode_value, tc(0, 10, 0, 0));
    drop_frame_en = 1'b0;
    tc_mode = tcg_pkg::TCG_MODE_REC_RUN;
    tick();
    chk("gen", generator_timecode_value, tc(0, 10, 0, 0));
    recording = 1'b1;
    tick();
    chk("gen", generator_timecode_value, tc(0, 10, 0, 1));
    recording = 1'b0;
    tc_mode = tcg_pkg::TCG_MODE_FREE;
    // frozen clock enable must hold the count
    clk_en = 1'b0;
    tick();
    chk("gen", generator_timecode_value, tc(0, 10, 0, 1));
    clk_en = 1'b1;
  endtask
  task automatic t_ub();
    for (int i = 0; i < 3; i++) wr(2'(i), 8'ha0 + 8'(i));
    wr(3, 8'hff);
    chk("ub", user_bit_groups, 32'ha0a1a2ff);
    ub_format = tcg_pkg::TCG_UB_MDY;
    wr(0, 8'h55);
    wr(3, 8'h3c);
    chk("ub", user_bit_groups, {sys_month, sys_day, sys_year, 8'h3c});
    ub_format = tcg_pkg::TCG_UB_DMY;
    cyc(3);
    chk("ub", user_bit_groups, {sys_day, sys_month, sys_year, 8'h3c});
    ub_format = tcg_pkg::TCG_UB_USER;
    cyc(3);
    chk("ub", user_bit_groups, 32'ha0a1a23c);
  endtask
  task automatic t_jam();
    src_on = 1'b1;
    jam_rx_stb = 1'b1;
    cyc(1);
    jam_rx_stb = 1'b0;
    cyc(2);
    chk("gen", generator_timecode_value, tc(1, 2, 3, 4));
    jam_view_open = 1'b1;
    cyc(2);
    chk("vrx", view_rx_tc_q, tc(1, 2, 3, 4));
    chk("vrxu", view_rx_ub_q, 32'h5a3c0f81);
    chk("vgen", view_gen_tc_q, tc(1, 2, 3, 4));
    chk("vgenu", view_gen_ub_q, 32'ha0a1a23c);
    jam_view_open = 1'b0;
    jam_tod_stb = 1'b1;
    cyc(1);
    jam_tod_stb = 1'b0;
    cyc(2);
    chk("gen", generator_timecode_value, tc(13, 14, 15, 0));
    tc_mode = tcg_pkg::TCG_MODE_EXT_LTC;
    tick();
    chk("gen", generator_timecode_value, tc(1, 2, 3, 4));
    tc_mode = tcg_pkg::TCG_MODE_FREE;
  endtask
  task automatic t_stamp();
    preset(0, 0, 1, 25);
    start_offset = 5'sd10;
    stamp();
    chk("stamp", file_start_tc_q, tc(0, 0, 1, 29));
    chk("gen", generator_timecode_value, tc(0, 0, 1, 25));
    preset(0, 0, 1, 3);
    start_offset = -5'sd10;
    stamp();
    chk("stamp", file_start_tc_q, tc(0, 0, 1, 0));
    start_offset = 5'sd0;
    for (int r = 0; r < 7; r++) begin
      file_rate = 3'(r);
      stamp();
      chk("rate", file_rate_q, r);
    end
    video_mode = 1'b1;
    file_rate = 3'h0;
    stamp();
    chk("rate", file_rate_q, 3);
    video_mode = 1'b0;
    file_rate = 3'h3;
  endtask
  task automatic t_refs();
    logic [4:0] sel[5] = '{0, 2, 19, 20, 21};
    logic [1:0] src[5] = '{0, 1, 1, 2, 3};
    logic [4:0] fmt[5] = '{0, 2, 19, 0, 0};
    for (int r = 0; r < 6; r++) begin
      audio_ref_sel = 3'(r);
      cyc(2);
      chk("aref", clk_ref_q, r);
    end
    video_mode = 1'b1;
    for (int r = 0; r < 3; r++) begin
      video_ref_sel = 2'(r);
      cyc(2);
      chk("vref", clk_ref_q, r);
    end
    video_mode = 1'b0;
    for (int i = 0; i < 5; i++) begin
      sync_out_sel = sel[i];
      cyc(2);
      chk("ssrc", sync_src_q, src[i]);
      chk("sfmt", sync_fmt_q, fmt[i]);
    end
    for (int m = 0; m < 8; m++) begin
      tc_mode = 3'(m);
      cyc(2);
      chk("run", gen_running_q, 8'he6 >> m & 1);
      if (m != 3) chk("mute", gen_mute_q, 8'h15 >> m & 1);
    end
    tc_mode = tcg_pkg::TCG_MODE_FREE;
  endtask
  task automatic t_trig(input logic [3:0] h, input int n, input int exp);
    int seen;
    seen = 0;
    holdoff_sec = h;
    tc_trigger_en = 1'b1;
    src_on = 1'b0;
    cyc(2);
    src_on = 1'b1;
    repeat (n) begin
      cyc(1);
      if (take_start_q === 1'b1) seen++;
    end
    chk("takes", seen, exp);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (6000) @(posedge sys_clk);
    errors++;
    end_sim();
  end
  initial begin
    {rst_n, frame_tick, video_mode, recording, drop_frame_en, preset_stb, ub_wr, src_on} = '0;
    {jam_rx_stb, jam_tod_stb, tc_trigger_en, file_start_stb, jam_view_open} = '0;
    {ub_slot_sel, ub_format, video_ref_sel, tc_mode, audio_ref_sel, holdoff_sec, sync_out_sel} = '0;
    {preset_hh, preset_mm, preset_ss, preset_ff, ub_wdata, start_offset} = '0;
    clk_en = 1'b1;
    file_rate = 3'h3;
    {sys_month, sys_day, sys_year} = {8'h12, 8'h31, 8'h25};
    {tod_hh, tod_mm, tod_ss} = {5'h0d, 6'h0e, 6'h0f};
    cyc(20);
    rst_n = 1'b1;
    cyc(1);
    t_rst();
    t_count();
    t_ub();
    t_jam();
    t_stamp();
    t_refs();
    t_trig(0, 10, 1);
    t_trig(1, 300, 0);
    end_sim();
  end
endmodule // tcg_top_tb_top
